/* sim/analog_side_model.sv */
`default_nettype none
module analog_side_model (
  input wire logic ref_clk,
  input wire logic [3:0] supplyLevel,
  input wire logic [3:0] pfThreshold,
  input wire logic pfActive,
  output logic pfBelowRaw
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pfBelowRaw = 1'b0;
  // an unpowered comparator rests low, it never holds an old verdict
  always @(posedge ref_clk) begin
    pfBelowRaw <= pfActive && (supplyLevel < pfThreshold);
  end
endmodule : analog_side_model
`default_nettype wire

/* sim/power_supply_control_checker.sv */
`default_nettype none
module power_supply_control_checker
  import power_supply_control_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic regRead,
  input wire reg_data_t regRdata,
  input wire logic vbusValidRaw,
  input wire logic usbDeviceEnable,
  input wire logic highSupplyMode,
  input wire logic stage1LinearEn,
  input wire logic stage1SwitchEn,
  input wire logic stage2LinearEn,
  input wire logic stage2SwitchEn,
  input wire logic pfActive,
  input wire logic flashWriteInhibit,
  input wire logic usbRegulatorOn,
  input wire logic pfWarnEvent,
  input wire logic busDetectedEvent,
  input wire logic busRemovedEvent,
  input wire logic usbPowerReadyEvent,
  input wire logic wakeResetReq,
  input wire logic systemOn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // enables lag the mode flop by one edge, so two normal cycles are needed
  stage1_normal_a: assert property (!highSupplyMode && !$past(highSupplyMode) |-> !stage1LinearEn && !stage1SwitchEn)
    else $error("first stage on in normal mode");
  one_type_a: assert property (!(stage1LinearEn && stage1SwitchEn) && !(stage2LinearEn && stage2SwitchEn))
    else $error("two regulator types on");
  flash_block_a: assert property (flashWriteInhibit |-> pfActive || $past(pfActive))
    else $error("inhibit without comparator");
  warn_active_a: assert property (pfWarnEvent |-> $past(pfActive))
    else $error("warning while comparator idle");
  detect_once_a: assert property (busDetectedEvent |-> $past(vbusValidRaw, 2) ##1 !busDetectedEvent)
    else $error("bad detected event");
  removed_sync_a: assert property (busRemovedEvent |-> !$past(vbusValidRaw, 2))
    else $error("bad removed event");
  usb_enable_a: assert property (usbRegulatorOn |-> $past(usbDeviceEnable))
    else $error("usb regulator on without enable");
  settle_time_a: assert property ($rose(usbRegulatorOn) ##0 (usbRegulatorOn throughout ##20 1'b1) |-> usbPowerReadyEvent)
    else $error("ready event late");
  settle_min_a: assert property (usbPowerReadyEvent |-> $past(usbRegulatorOn, 20))
    else $error("ready event early");
  wake_reset_a: assert property (wakeResetReq |-> systemOn && !$past(systemOn) && busDetectedEvent)
    else $error("bad wakeup reset");
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
endmodule : power_supply_control_checker
bind power_supply_control power_supply_control_checker i_power_supply_control_checker (.*);
`default_nettype wire

/* sim/power_supply_control_test.sv */
`include "power_supply_control_map.svh"
`default_nettype none
module power_supply_control_test import power_supply_control_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdPend = 1'b0;
  logic vddExternal = 1'b0, hfClockRunning = 1'b1, vbusValidRaw = 1'b0;
  logic usbDeviceEnable = 1'b0, systemOffRequest = 1'b0, pfBelowRaw;
  logic [3:0] supplyLevel = 4'h8;
  reg_addr_t regAddr = 8'h00;
  reg_data_t regWdata = 32'h0, regRdata, seed = 32'hff317b9f;
  reg_data_t expq[$];
  logic stage1LinearEn, stage1SwitchEn, stage2LinearEn, stage2SwitchEn, externalSupplyEn;
  logic pfActive, flashWriteInhibit, usbRegulatorOn, systemOn, highSupplyMode, usbPowerReady;
  logic [`LEVEL_W-1:0] stage1Level;
  logic [`THRESH_W-1:0] pfThreshold;
  int num_errors = 0, samples_checked = 0;
  power_supply_control i_power_supply_control (.ref_clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .vddExternal, .pfBelowRaw, .hfClockRunning, .vbusValidRaw, .usbDeviceEnable, .systemOffRequest,
    .highSupplyMode, .stage1LinearEn, .stage1SwitchEn, .stage2LinearEn, .stage2SwitchEn, .stage1Level,
    .externalSupplyEn, .pfActive, .pfThreshold, .flashWriteInhibit, .usbRegulatorOn, .usbPowerReady,
    .pfWarnEvent(), .busDetectedEvent(), .busRemovedEvent(), .usbPowerReadyEvent(), .wakeResetReq(), .systemOn);
  analog_side_model i_analog_side_model (.ref_clk, .supplyLevel, .pfThreshold, .pfActive, .pfBelowRaw);
  initial forever #25 ref_clk = ~ref_clk;
  function automatic reg_data_t xs(input reg_data_t s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task wrap_up;
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task chk(input reg_data_t got, input reg_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t port value %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input reg_addr_t a, input reg_data_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  task rd(input reg_addr_t a, input reg_data_t e);
    @(posedge ref_clk);
    expq.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask : rd
  // read data is only valid in the slot right after the strobe
  always @(posedge ref_clk) begin
    if (rdPend) begin
      samples_checked++;
      if (regRdata !== expq[0]) begin
        num_errors++;
        $display("ERROR %0t read %h, expected %h", $time, regRdata, expq[0]);
      end
      void'(expq.pop_front());
    end
    rdPend <= regRead;
  end
  task pfCase(input logic hf, input logic [3:0] l0, l1, input logic [4:0] cfg, input logic ev, inh);
    hfClockRunning <= hf;
    supplyLevel <= l0;
    tick(10);
    wr(`OFF_EVENTS, 32'h1);
    wr(`OFF_PF_CONFIG, 32'(cfg));
    tick(10);
    supplyLevel <= l1;
    tick(10);
    chk(32'(pfThreshold), 32'(cfg[4:1]));
    chk(32'(flashWriteInhibit), 32'(inh));
    rd(`OFF_EVENTS, 32'(ev));
  endtask : pfCase
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    tick(1);
    chk(32'({stage2LinearEn, stage1SwitchEn, stage2SwitchEn, pfActive, systemOn}), 32'h11);
    wr(8'h1c, 32'hffffffff);
    for (int i = 1; i < 8; i++) rd(8'(i * 4), 32'h0);
    tick(8);
    rd(`OFF_MODE_STATUS, 32'h1);
    chk(32'({highSupplyMode, stage1LinearEn, externalSupplyEn}), 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_SWITCHER, 32'(i));
      tick(2);
      chk(32'({stage2SwitchEn, stage1SwitchEn, stage2LinearEn, stage1LinearEn}), 32'({i[1:0], ~i[1:0]}));
    end
    rd(`OFF_SWITCHER, 32'h3);
    seed = xs(seed);
    wr(`OFF_STAGE1_LEVEL, seed);
    wr(`OFF_MODE_STATUS, 32'h0);
    rd(`OFF_STAGE1_LEVEL, seed & 32'h7);
    rd(`OFF_MODE_STATUS, 32'h1);
    chk(32'(stage1Level), 32'(seed[2:0]));
    vddExternal <= 1'b1;
    tick(10);
    rd(`OFF_MODE_STATUS, 32'h0);
    chk(32'({highSupplyMode, stage1LinearEn, stage1SwitchEn, stage2LinearEn, stage2SwitchEn}), 32'h1);
    wr(`OFF_SWITCHER, 32'h0);
    vddExternal <= 1'b0;
    pfCase(1'b1, 4'h8, 4'h8, 5'h09, 1'b0, 1'b0);
    pfCase(1'b1, 4'h8, 4'h2, 5'h09, 1'b1, 1'b1);
    pfCase(1'b1, 4'h8, 4'h8, 5'h19, 1'b1, 1'b1);
    pfCase(1'b1, 4'h2, 4'h2, 5'h08, 1'b0, 1'b0);
    pfCase(1'b1, 4'h2, 4'h2, 5'h09, 1'b1, 1'b1);
    pfCase(1'b0, 4'h8, 4'h2, 5'h09, 1'b0, 1'b0);
    hfClockRunning <= 1'b1;
    supplyLevel <= 4'h8;
    vbusValidRaw <= 1'b1;
    tick(30);
    chk(32'(usbRegulatorOn), 32'h0);
    rd(`OFF_USB_STATUS, 32'h1);
    wr(`OFF_EVENTS, 32'hf);
    usbDeviceEnable <= 1'b1;
    tick(12);
    chk(32'({usbRegulatorOn, usbPowerReady}), 32'h2);
    rd(`OFF_USB_STATUS, 32'h1);
    tick(10);
    rd(`OFF_USB_STATUS, 32'h3);
    chk(32'(usbPowerReady), 32'h1);
    vbusValidRaw <= 1'b0;
    tick(8);
    chk(32'({usbRegulatorOn, usbPowerReady}), 32'h0);
    rd(`OFF_EVENTS, 32'hc);
    wr(`OFF_EVENTS, 32'hf);
    vbusValidRaw <= 1'b1;
    tick(14);
    rd(`OFF_USB_STATUS, 32'h1);
    tick(10);
    rd(`OFF_EVENTS, 32'ha);
    usbDeviceEnable <= 1'b0;
    vbusValidRaw <= 1'b0;
    tick(10);
    wr(`OFF_EVENTS, 32'hf);
    systemOffRequest <= 1'b1;
    tick(1);
    systemOffRequest <= 1'b0;
    supplyLevel <= 4'h2;
    tick(10);
    chk(32'({systemOn, pfActive, externalSupplyEn}), 32'h1);
    rd(`OFF_EVENTS, 32'h0);
    supplyLevel <= 4'h8;
    tick(10);
    vbusValidRaw <= 1'b1;
    tick(8);
    chk(32'(systemOn), 32'h1);
    rd(`OFF_RESET_REASON, 32'h1);
    wr(`OFF_RESET_REASON, 32'h1);
    rd(`OFF_RESET_REASON, 32'h0);
    tick(3);
    wrap_up();
  end
  initial begin
    #(50 * 20000);
    num_errors++;
    wrap_up();
  end
endmodule : power_supply_control_test
`default_nettype wire

/* src/power_supply_control.sv */
// Design decisions made here: the register offsets and the strobed register port.
`include "power_supply_control_map.svh"
`default_nettype none

// Contract
// - detect supply mode, show in status
// - normal mode disables first stage automatically
// - first stage output level is software field
// - reset: linear on, switchers off, separate enables; first stage linear resets off until high mode is seen
// - switcher enabled turns that stage's linear off
// - first stage output kept in off and on
// - comparator off unless enabled; config register
// - warn when supply falls below threshold
// - warn if already below on enable/rethreshold
// - below threshold while enabled blocks flash writes
// - comparator idle in off or clock stopped
// - event when bus supply becomes valid
// - event when bus supply is removed
// - bus valid while off: reset, go on
// - bus wakeup sets reset reason bit
// - usb regulator on: enabled and bus valid
// - ready event after regulator settling time
// - bus detect and ready readable anytime
module power_supply_control
  import power_supply_control_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire reg_addr_t regAddr,
  input wire reg_data_t regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output reg_data_t regRdata,
  input wire logic vddExternal,
  input wire logic pfBelowRaw,
  input wire logic hfClockRunning,
  input wire logic vbusValidRaw,
  input wire logic usbDeviceEnable,
  input wire logic systemOffRequest,
  output logic highSupplyMode,
  output logic stage1LinearEn,
  output logic stage1SwitchEn,
  output logic stage2LinearEn,
  output logic stage2SwitchEn,
  output logic [`LEVEL_W-1:0] stage1Level,
  output logic externalSupplyEn,
  output logic pfActive,
  output logic [`THRESH_W-1:0] pfThreshold,
  output logic flashWriteInhibit,
  output logic usbRegulatorOn,
  output logic usbPowerReady,
  output logic pfWarnEvent,
  output logic busDetectedEvent,
  output logic busRemovedEvent,
  output logic usbPowerReadyEvent,
  output logic wakeResetReq,
  output logic systemOn
);

  function automatic logic hit(input reg_addr_t addr, input reg_addr_t off);
    hit = (addr == off);
  endfunction : hit

  logic [`ASYNC_N-1:0] asyncIn;
  logic [`ASYNC_N-1:0] syncA;
  logic [`ASYNC_N-1:0] syncB;
  logic vbusPrev;
  logic pfQualPrev;
  logic pfQual;
  logic vbusRise;
  logic vbusFall;
  logic pfRise;
  logic pfRecheck;
  logic [`CNT_W-1:0] pfSettleCnt;
  logic swStage1;
  logic swStage2;
  logic pfEnable;
  logic [`EV_W-1:0] events;
  logic [`EV_W-1:0] evSet;
  logic [`EV_W-1:0] evClr;
  logic wakeVbus;
  logic usbOnReq;
  usb_state_t usbState;
  usb_state_t next_usbState;
  logic [`CNT_W-1:0] usbSettleCnt;
  logic usbReadyHit;
  reg_data_t next_regRdata;

  assign asyncIn[`IN_VDD] = vddExternal;
  assign asyncIn[`IN_PF] = pfBelowRaw;
  assign asyncIn[`IN_HF] = hfClockRunning;
  assign asyncIn[`IN_VBUS] = vbusValidRaw;

  // the supply pin sync rests at normal mode, so the first stage cannot glitch on after reset
  genvar gi;
  generate
    for (gi = 0; gi < `ASYNC_N; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          syncA[gi] <= (gi == `IN_VDD);
          syncB[gi] <= (gi == `IN_VDD);
        end else begin
          syncA[gi] <= asyncIn[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  // comparator result only counts while the comparator may run
  assign pfQual = pfActive & syncB[`IN_PF];
  assign pfRise = pfQual & ~pfQualPrev;
  assign vbusRise = syncB[`IN_VBUS] & ~vbusPrev;
  assign vbusFall = ~syncB[`IN_VBUS] & vbusPrev;
  assign pfRecheck = pfQual & ~pfRise & (pfSettleCnt == `CNT_W'(1));
  assign usbOnReq = usbDeviceEnable & syncB[`IN_VBUS];
  assign usbReadyHit = (usbSettleCnt == `CNT_W'(`USB_SETTLE_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      vbusPrev <= 1'b0;
      pfQualPrev <= 1'b0;
    end else begin
      vbusPrev <= syncB[`IN_VBUS];
      pfQualPrev <= pfQual;
    end
  end

  // supply mode follows the pins: no outside supply on the low pin means high mode
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      highSupplyMode <= 1'b0;
    end else begin
      highSupplyMode <= ~syncB[`IN_VDD];
    end
  end

  // regulator stage selection
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1LinearEn <= 1'b0;
      stage1SwitchEn <= 1'b0;
      stage2LinearEn <= 1'b1;
      stage2SwitchEn <= 1'b0;
      externalSupplyEn <= 1'b0;
    end else begin
      stage1LinearEn <= highSupplyMode & ~swStage1;
      stage1SwitchEn <= highSupplyMode & swStage1;
      stage2LinearEn <= ~swStage2;
      stage2SwitchEn <= swStage2;
      // not gated by systemOn: external loads stay powered while off
      externalSupplyEn <= highSupplyMode;
    end
  end

  // software configuration
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1Level <= `LEVEL_RESET;
      swStage1 <= 1'b0;
      swStage2 <= 1'b0;
      pfEnable <= 1'b0;
      pfThreshold <= `THRESH_RESET;
    end else if (regWrite) begin
      if (hit(regAddr, `OFF_STAGE1_LEVEL)) begin
        stage1Level <= regWdata[`LEVEL_W-1:0];
      end
      if (hit(regAddr, `OFF_SWITCHER)) begin
        swStage1 <= regWdata[`BIT_SW_STAGE1];
        swStage2 <= regWdata[`BIT_SW_STAGE2];
      end
      if (hit(regAddr, `OFF_PF_CONFIG)) begin
        pfEnable <= regWdata[`BIT_PF_ENABLE];
        pfThreshold <= regWdata[`FLD_PF_THRESH_HI:`FLD_PF_THRESH_LO];
      end
    end
  end

  // comparator activity
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pfActive <= 1'b0;
      flashWriteInhibit <= 1'b0;
    end else begin
      pfActive <= pfEnable & systemOn & syncB[`IN_HF];
      flashWriteInhibit <= pfQual;
    end
  end

  // a new threshold needs the analog output to settle and pass the synchroniser;
  // if it then reads below without an edge the warning is still owed
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pfSettleCnt <= '0;
    end else if (regWrite && hit(regAddr, `OFF_PF_CONFIG) && regWdata[`BIT_PF_ENABLE]) begin
      pfSettleCnt <= `CNT_W'(`PF_SETTLE_CYCLES);
    end else if (pfSettleCnt != '0) begin
      pfSettleCnt <= pfSettleCnt - `CNT_W'(1);
    end
  end

  // system on/off and bus wakeup
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      systemOn <= 1'b1;
      wakeResetReq <= 1'b0;
    end else begin
      wakeResetReq <= 1'b0;
      if (!systemOn && vbusRise) begin
        systemOn <= 1'b1;
        wakeResetReq <= 1'b1;
      end else if (systemOffRequest) begin
        systemOn <= 1'b0;
      end
    end
  end

  // reset reason lives here, so the wakeup reset we request must not clear it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wakeVbus <= 1'b0;
    end else if (!systemOn && vbusRise) begin
      wakeVbus <= 1'b1;
    end else if (regWrite && hit(regAddr, `OFF_RESET_REASON) && regWdata[`BIT_WAKE_VBUS]) begin
      wakeVbus <= 1'b0;
    end
  end

  // usb regulator sequencing
  always_comb begin
    next_usbState = usbState;
    case (usbState)
      USB_OFF: begin
        if (usbOnReq) begin
          next_usbState = USB_SETTLING;
        end
      end
      USB_SETTLING: begin
        if (!usbOnReq) begin
          next_usbState = USB_OFF;
        end else if (usbReadyHit) begin
          next_usbState = USB_READY;
        end
      end
      USB_READY: begin
        if (!usbOnReq) begin
          next_usbState = USB_OFF;
        end
      end
      default: begin
        next_usbState = USB_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      usbState <= USB_OFF;
      usbRegulatorOn <= 1'b0;
      usbPowerReady <= 1'b0;
    end else begin
      usbState <= next_usbState;
      usbRegulatorOn <= (next_usbState != USB_OFF);
      usbPowerReady <= (next_usbState == USB_READY);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      usbSettleCnt <= '0;
    end else if (vbusFall || usbState != USB_SETTLING) begin
      usbSettleCnt <= '0;
    end else if (!usbReadyHit) begin
      usbSettleCnt <= usbSettleCnt + `CNT_W'(1);
    end
  end

  // events: one pulse per qualifying transition, also kept as sticky flags
  always_comb begin
    evSet = '0;
    evSet[`EV_PF] = pfRise | pfRecheck;
    evSet[`EV_DET] = vbusRise;
    evSet[`EV_REM] = vbusFall;
    evSet[`EV_RDY] = (usbState == USB_SETTLING) && (next_usbState == USB_READY);
    evClr = '0;
    if (regWrite && hit(regAddr, `OFF_EVENTS)) begin
      evClr = regWdata[`EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      events <= '0;
      pfWarnEvent <= 1'b0;
      busDetectedEvent <= 1'b0;
      busRemovedEvent <= 1'b0;
      usbPowerReadyEvent <= 1'b0;
    end else begin
      // a set in the same cycle as its clear survives
      events <= (events & ~evClr) | evSet;
      pfWarnEvent <= evSet[`EV_PF];
      busDetectedEvent <= evSet[`EV_DET];
      busRemovedEvent <= evSet[`EV_REM];
      usbPowerReadyEvent <= evSet[`EV_RDY];
    end
  end

  // register reads, data valid only in the following cycle
  always_comb begin
    next_regRdata = '0;
    if (regRead) begin
      if (hit(regAddr, `OFF_MODE_STATUS)) begin
        next_regRdata[`BIT_HIGH_MODE] = highSupplyMode;
      end
      if (hit(regAddr, `OFF_STAGE1_LEVEL)) begin
        next_regRdata[`LEVEL_W-1:0] = stage1Level;
      end
      if (hit(regAddr, `OFF_SWITCHER)) begin
        next_regRdata[`BIT_SW_STAGE1] = swStage1;
        next_regRdata[`BIT_SW_STAGE2] = swStage2;
      end
      if (hit(regAddr, `OFF_PF_CONFIG)) begin
        next_regRdata[`BIT_PF_ENABLE] = pfEnable;
        next_regRdata[`FLD_PF_THRESH_HI:`FLD_PF_THRESH_LO] = pfThreshold;
      end
      if (hit(regAddr, `OFF_EVENTS)) begin
        next_regRdata[`EV_W-1:0] = events;
      end
      if (hit(regAddr, `OFF_USB_STATUS)) begin
        next_regRdata[`BIT_VBUS_DET] = syncB[`IN_VBUS];
        next_regRdata[`BIT_USB_RDY] = usbPowerReady;
      end
      if (hit(regAddr, `OFF_RESET_REASON)) begin
        next_regRdata[`BIT_WAKE_VBUS] = wakeVbus;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      regRdata <= '0;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule : power_supply_control

`default_nettype wire

/* src/power_supply_control_map.svh */
`ifndef POWER_SUPPLY_CONTROL_MAP_SVH
`define POWER_SUPPLY_CONTROL_MAP_SVH

`define OFF_MODE_STATUS 8'h00
`define OFF_STAGE1_LEVEL 8'h04
`define OFF_SWITCHER 8'h08
`define OFF_PF_CONFIG 8'h0c
`define OFF_EVENTS 8'h10
`define OFF_USB_STATUS 8'h14
`define OFF_RESET_REASON 8'h18

`define LEVEL_W 3
`define THRESH_W 4
`define LEVEL_RESET 3'h0
`define THRESH_RESET 4'h0

`define BIT_HIGH_MODE 0
`define BIT_SW_STAGE1 0
`define BIT_SW_STAGE2 1
`define BIT_PF_ENABLE 0
`define FLD_PF_THRESH_LO 1
`define FLD_PF_THRESH_HI 4

`define EV_W 4
`define EV_PF 0
`define EV_DET 1
`define EV_REM 2
`define EV_RDY 3

`define BIT_VBUS_DET 0
`define BIT_USB_RDY 1
`define BIT_WAKE_VBUS 0

`define ASYNC_N 4
`define IN_VDD 0
`define IN_PF 1
`define IN_HF 2
`define IN_VBUS 3

`define CLK_PERIOD_NS 50
`define USB_SETTLE_NS 1000
`define USB_SETTLE_CYCLES ((`USB_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PF_SETTLE_CYCLES 4
`define CNT_W 8

`endif

/* src/power_supply_control_pkg.sv */
`default_nettype none

package power_supply_control_pkg;

  typedef enum logic [1:0] {
    USB_OFF = 2'b00,
    USB_SETTLING = 2'b01,
    USB_READY = 2'b11
  } usb_state_t;

  typedef logic [7:0] reg_addr_t;
  typedef logic [31:0] reg_data_t;

endpackage : power_supply_control_pkg

`default_nettype wire
